// File: src/ram_alias_mailbox.sv
// remote-target alias translator (entries 4 to 7) and two message
// registers, with one register port for each end of the serial link.
// assumes the i2c slave engines deliver decoded register accesses and
// target addresses on this clock; physical addresses come from outside.
//
// What this block does
// - each alias entry keeps a 7-bit value in bits 7:1 for matching.
// - a matching transaction gets the entry's physical address instead.
// - physical addresses are 7 bits; substitution precedes forwarding.
// - an alias value of zero never matches, disabling that entry.
// - all alias entries reset to zero, so nothing forwards after reset.
// - alias entries five, six, seven live at 0x15, 0x16, 0x17, r/w.
// - message registers are plain 8-bit stores with no side effects.
// - message b sits at 0x19 resetting to 0x1; a at 0x18, zero.
// - message registers are reachable from controllers at both ends.
`timescale 1ns/1ps
`default_nettype none

module ram_alias_mailbox #(
  parameter int unsigned ENTRIES = ram_pkg::ALIAS_ENTRIES
) (
  input  wire logic                     clk,        // register clock
  input  wire logic                     rst_b,      // async reset, low
  input  wire ram_pkg::ram_reg_req_s    loc_req,    // local port access
  output logic [7:0]                    loc_rdata,  // local read data
  output logic                          loc_rvalid, // local read done
  input  wire ram_pkg::ram_reg_req_s    rem_req,    // remote port access
  output logic [7:0]                    rem_rdata,  // remote read data
  output logic                          rem_rvalid, // remote read done
  input  wire logic [ENTRIES-1:0][6:0]  phys_addr,  // physical_target_addr
  input  wire ram_pkg::ram_xact_s       xact_in,    // incoming address
  output ram_pkg::ram_xact_s            fwd_out,    // remapped, to channel
  output logic [1:0]                    fwd_entry,  // entry that matched
  output logic                          drop_pulse  // no enabled match
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  // the map holds exactly four consecutive alias slots below the
  // message registers, so no other count can be served
  if (ENTRIES != ram_pkg::ALIAS_ENTRIES)
  begin : g_bad_entries
    $error("ram_alias_mailbox: ENTRIES must be 4");
  end
  // the alias field must be exactly one target address wide and the
  // entry index must reach every slot, or values are silently cut
  if (ram_pkg::ALIAS_MSB - ram_pkg::ALIAS_LSB + 1 != ram_pkg::TADDR_W)
  begin : g_bad_field
    $error("ram_alias_mailbox: alias field width mismatch");
  end
  if ((1 << ram_pkg::IDX_W) < ENTRIES)
  begin : g_bad_index
    $error("ram_alias_mailbox: entry index too narrow");
  end
  // the message registers must follow the last alias slot directly
  if (ram_pkg::SCRATCH_A_ADDR != ram_pkg::ALIAS_E4_ADDR + 8'(ENTRIES) ||
      ram_pkg::SCRATCH_B_ADDR != ram_pkg::SCRATCH_A_ADDR + 8'h01)
  begin : g_bad_map
    $error("ram_alias_mailbox: message registers misplaced");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [ENTRIES-1:0][6:0] alias_q;
  logic [7:0]              scratch_a_q;
  logic [7:0]              scratch_b_q;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // true when the register address selects alias slot idx
  function automatic logic is_alias(input logic [7:0] addr,
                                    input int unsigned idx);
    logic [7:0] slot;
    slot = ram_pkg::ALIAS_E4_ADDR + 8'(idx);
    return addr == slot;
  endfunction

  // true when a port writes the register at addr this cycle
  function automatic logic wr_sel(input ram_pkg::ram_reg_req_s req,
                                  input logic [7:0]            addr);
    return req.wr && req.addr == addr;
  endfunction

  // read value of any mapped register; unmapped reads give zero
  function automatic logic [7:0] read_mux(
    input logic [7:0]              addr,
    input logic [ENTRIES-1:0][6:0] als,
    input logic [7:0]              sa,
    input logic [7:0]              sb
  );
    logic [7:0] r;
    r = ram_pkg::READ_ZERO;
    for (int unsigned i = 0; i < ENTRIES; i++)
    begin
      if (is_alias(addr, i))
      begin
        r = {als[i], 1'b0};
      end
    end
    if (addr == ram_pkg::SCRATCH_A_ADDR)
    begin
      r = sa;
    end
    if (addr == ram_pkg::SCRATCH_B_ADDR)
    begin
      r = sb;
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // alias entries
  // ---------------------------------------------------------------
  // both ends may program an alias; the local side wins a same-cycle
  // collision on one register, the remote write is then lost
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int unsigned i = 0; i < ENTRIES; i++)
      begin
        alias_q[i] <= ram_pkg::ALIAS_RST;
      end
    end
    else
    begin
      for (int unsigned i = 0; i < ENTRIES; i++)
      begin
        if (loc_req.wr && is_alias(loc_req.addr, i))
        begin
          // bit 0 of the write data is dropped
          alias_q[i] <= loc_req.wdata[ram_pkg::ALIAS_MSB:
                                      ram_pkg::ALIAS_LSB];
        end
        else if (rem_req.wr && is_alias(rem_req.addr, i))
        begin
          alias_q[i] <= rem_req.wdata[ram_pkg::ALIAS_MSB:
                                      ram_pkg::ALIAS_LSB];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // message registers
  // ---------------------------------------------------------------
  // plain stores: nothing else in the block reads them
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scratch_a_q <= ram_pkg::SCRATCH_A_RST;
    end
    else if (wr_sel(loc_req, ram_pkg::SCRATCH_A_ADDR))
    begin
      scratch_a_q <= loc_req.wdata;
    end
    else if (wr_sel(rem_req, ram_pkg::SCRATCH_A_ADDR))
    begin
      scratch_a_q <= rem_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scratch_b_q <= ram_pkg::SCRATCH_B_RST;
    end
    else if (wr_sel(loc_req, ram_pkg::SCRATCH_B_ADDR))
    begin
      scratch_b_q <= loc_req.wdata;
    end
    else if (wr_sel(rem_req, ram_pkg::SCRATCH_B_ADDR))
    begin
      scratch_b_q <= rem_req.wdata;
    end
  end

  // ---------------------------------------------------------------
  // read ports
  // ---------------------------------------------------------------
  // read data is held until the next read on that port
  // a read and a write in the same cycle return the old value
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      loc_rdata  <= ram_pkg::READ_ZERO;
      loc_rvalid <= 1'b0;
    end
    else
    begin
      loc_rvalid <= loc_req.rd;
      if (loc_req.rd)
      begin
        loc_rdata <= read_mux(loc_req.addr, alias_q,
                              scratch_a_q, scratch_b_q);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rem_rdata  <= ram_pkg::READ_ZERO;
      rem_rvalid <= 1'b0;
    end
    else
    begin
      rem_rvalid <= rem_req.rd;
      if (rem_req.rd)
      begin
        rem_rdata <= read_mux(rem_req.addr, alias_q,
                              scratch_a_q, scratch_b_q);
      end
    end
  end

  // ---------------------------------------------------------------
  // alias match
  // ---------------------------------------------------------------
  logic               hit;
  logic [1:0]         hit_idx;
  logic [6:0]         hit_phys;
  logic [ENTRIES-1:0] entry_on;

  // a zero alias switches its entry off, so a transaction addressed to
  // zero can never reach the remote side through an unused slot
  always_comb
  begin
    entry_on = '0;
    for (int unsigned i = 0; i < ENTRIES; i++)
    begin
      entry_on[i] = alias_q[i] != ram_pkg::ALIAS_OFF;
    end
  end

  // the lowest numbered entry wins if software programs duplicates
  always_comb
  begin
    hit      = 1'b0;
    hit_idx  = 2'h0;
    hit_phys = 7'h00;
    for (int i = ENTRIES - 1; i >= 0; i--)
    begin
      if (entry_on[i] &&
          alias_q[i] == xact_in.addr)
      begin
        hit      = 1'b1;
        hit_idx  = 2'(i);
        hit_phys = phys_addr[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // forward to control channel
  // ---------------------------------------------------------------
  // one cycle of latency; the channel sees only the physical address
  // addr, rnw and entry keep the last forwarded values; only the valid
  // pulse says that something new went out
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fwd_out   <= '0;
      fwd_entry <= 2'h0;
    end
    else
    begin
      fwd_out.valid <= xact_in.valid && hit;
      if (xact_in.valid && hit)
      begin
        fwd_out.addr <= hit_phys;
        fwd_out.rnw  <= xact_in.rnw;
        fwd_entry    <= hit_idx;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      drop_pulse <= 1'b0;
    end
    // a refused transaction is reported rather than silently swallowed,
    // so the engine in front can answer it locally
    else
    begin
      drop_pulse <= xact_in.valid && !hit;
    end
  end

endmodule

`default_nettype wire

// File: src/ram_pkg.sv
// package for the remote-target alias translator and message registers
// assumes an 8-bit register address space clocked on the register clock
package ram_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ALIAS_E4_ADDR  = 8'h14;
  localparam logic [7:0] ALIAS_E5_ADDR  = 8'h15;
  localparam logic [7:0] ALIAS_E6_ADDR  = 8'h16;
  localparam logic [7:0] ALIAS_E7_ADDR  = 8'h17;
  localparam logic [7:0] SCRATCH_A_ADDR = 8'h18;
  localparam logic [7:0] SCRATCH_B_ADDR = 8'h19;

  localparam int unsigned ALIAS_ENTRIES = 4;
  localparam int unsigned ALIAS_MSB     = 7;
  localparam int unsigned ALIAS_LSB     = 1;
  localparam int unsigned TADDR_W       = 7;
  localparam int unsigned IDX_W         = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [6:0] ALIAS_RST     = 7'h00;
  localparam logic [6:0] ALIAS_OFF     = 7'h00;
  localparam logic [7:0] SCRATCH_A_RST = 8'h00;
  localparam logic [7:0] SCRATCH_B_RST = 8'h01;
  localparam logic [7:0] READ_ZERO     = 8'h00;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ram_reg_req_s;

  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
    logic       rnw;
  } ram_xact_s;

endpackage

// File: verification/ram_alias_mailbox_checker.sv
// checker for the alias translator and message registers
// assumes one clock domain and the port set of ram_alias_mailbox
`timescale 1ns/1ps
`default_nettype none
module ram_alias_mailbox_checker #(
  parameter int unsigned ENTRIES = 4
) (
  input wire logic                    clk,        // register clock
  input wire logic                    rst_b,      // async reset, low
  input wire ram_pkg::ram_reg_req_s   loc_req,    // local access
  input wire logic [7:0]              loc_rdata,  // local read data
  input wire logic                    loc_rvalid, // local read done
  input wire ram_pkg::ram_reg_req_s   rem_req,    // remote access
  input wire logic [7:0]              rem_rdata,  // remote read data
  input wire logic                    rem_rvalid, // remote read done
  input wire logic [ENTRIES-1:0][6:0] phys_addr,  // physical addresses
  input wire ram_pkg::ram_xact_s      xact_in,    // incoming address
  input wire ram_pkg::ram_xact_s      fwd_out,    // forwarded address
  input wire logic [1:0]              fwd_entry,  // matched entry
  input wire logic                    drop_pulse  // unmatched
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_fwd;
    xact_in.valid ##1 fwd_out.valid;
  endsequence
  AST_LRD: assert property (loc_req.rd |=> loc_rvalid)
    else $error("local read gave no valid");
  AST_LNO: assert property (!loc_req.rd |=> !loc_rvalid)
    else $error("local valid without read");
  AST_RRD: assert property (rem_req.rd |=> rem_rvalid)
    else $error("remote read gave no valid");
  AST_RNO: assert property (!rem_req.rd |=> !rem_rvalid)
    else $error("remote valid without read");
  AST_ONE: assert property (
    xact_in.valid |=> fwd_out.valid ^ drop_pulse)
    else $error("not exactly one of forward or drop");
  AST_IDL: assert property (
    !xact_in.valid |=> !fwd_out.valid && !drop_pulse)
    else $error("output without transaction");
  AST_PHY: assert property (
    s_fwd |-> fwd_out.addr == phys_addr[fwd_entry])
    else $error("forwarded address not physical");
  AST_RNW: assert property (s_fwd |-> fwd_out.rnw == $past(xact_in.rnw))
    else $error("direction bit not copied");
  AST_ZRO: assert property (
    xact_in.valid && xact_in.addr == 7'h00 |=> !fwd_out.valid)
    else $error("zero address forwarded");
  AST_RSV: assert property (
    loc_rvalid && $past(loc_req.addr[7:2]) == 6'h05 |-> loc_rdata[0] == 1'b0)
    else $error("alias bit 0 not zero");
  AST_RSR: assert property (
    rem_rvalid && $past(rem_req.addr[7:2]) == 6'h05 |-> rem_rdata[0] == 1'b0)
    else $error("remote alias bit 0 not zero");
endmodule
bind ram_alias_mailbox ram_alias_mailbox_checker #(.ENTRIES(ENTRIES)) u_chk (
  .clk(clk), .rst_b(rst_b), .loc_req(loc_req), .loc_rdata(loc_rdata),
  .loc_rvalid(loc_rvalid), .rem_req(rem_req), .rem_rdata(rem_rdata),
  .rem_rvalid(rem_rvalid), .phys_addr(phys_addr), .xact_in(xact_in),
  .fwd_out(fwd_out), .fwd_entry(fwd_entry), .drop_pulse(drop_pulse));
`default_nettype wire

// File: verification/ram_chan_model.sv
// far-side channel model: counts forwarded and dropped transactions
// assumes fwd and drop arrive as one-cycle pulses on clk
`timescale 1ns/1ps
`default_nettype none
module ram_chan_model (
  input  wire logic               clk,      // register clock
  input  wire logic               rst_b,    // async reset, low
  input  wire ram_pkg::ram_xact_s fwd_in,   // forwarded address
  input  wire logic               drop_in,  // dropped transaction
  output logic [7:0]              n_fwd_q,  // forwards taken
  output logic [7:0]              n_drop_q  // drops seen
);
  // only remapped addresses ever reach the far side
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) n_fwd_q <= 8'h00;
    else if (fwd_in.valid) n_fwd_q <= n_fwd_q + 8'h01;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) n_drop_q <= 8'h00;
    else if (drop_in) n_drop_q <= n_drop_q + 8'h01;
endmodule
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench for ram_alias_mailbox
// assumes package, design, checker and channel model compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                  clk = 1'b0;
  logic                  rst_b = 1'b0;
  ram_pkg::ram_reg_req_s loc_req = '0;
  ram_pkg::ram_reg_req_s rem_req = '0;
  ram_pkg::ram_xact_s    xact_in = '0;
  ram_pkg::ram_xact_s    fwd_out;
  logic [7:0]            loc_rdata, rem_rdata, n_fwd, n_drop;
  logic                  loc_rvalid, rem_rvalid, drop_pulse;
  logic [1:0]            fwd_entry;
  logic [3:0][6:0]       pa = {7'h53, 7'h52, 7'h51, 7'h50};
  int                    fail_count = 0;
  int                    checks = 0;
  always #2 clk = ~clk;
  ram_alias_mailbox u_dut (.clk(clk), .rst_b(rst_b), .loc_req(loc_req),
    .loc_rdata(loc_rdata), .loc_rvalid(loc_rvalid), .rem_req(rem_req),
    .rem_rdata(rem_rdata), .rem_rvalid(rem_rvalid), .phys_addr(pa),
    .xact_in(xact_in), .fwd_out(fwd_out), .fwd_entry(fwd_entry),
    .drop_pulse(drop_pulse));
  ram_chan_model u_chan (.clk(clk), .rst_b(rst_b), .fwd_in(fwd_out),
    .drop_in(drop_pulse), .n_fwd_q(n_fwd), .n_drop_q(n_drop));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic summarize;
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // one byte access; a read is judged on the cycle its answer stands
  task automatic acc(bit p, bit w, logic [7:0] a, logic [7:0] d);
    @(posedge clk) #1;
    if (p) rem_req = '{w, ~w, a, d};
    else loc_req = '{w, ~w, a, d};
    @(posedge clk) #1;
    loc_req = '0;
    rem_req = '0;
    if (!w) chk("rvalid", {7'h00, p ? rem_rvalid : loc_rvalid}, 8'h01);
    if (!w) chk("rdata", p ? rem_rdata : loc_rdata, d);
  endtask
  task automatic xa(logic [6:0] a, bit hit, logic [1:0] e);
    @(posedge clk) #1;
    xact_in = '{1'b1, a, e[0]};
    @(posedge clk) #1;
    xact_in = '0;
    chk("hit", {6'h00, fwd_out.valid, drop_pulse}, {6'h00, hit, ~hit});
    if (hit) chk("phys", {1'b0, fwd_out.addr}, {1'b0, pa[e]});
    if (hit) chk("entry", {6'h00, fwd_entry}, {6'h00, e});
    if (hit) chk("rnw", {7'h00, fwd_out.rnw}, {7'h00, e[0]});
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] ev [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
    for (int i = 0; i < 7; i++)
      acc(1'b0, 1'b0, 8'h14 + i[7:0], ev[i]);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b0, 1'b1, 8'h14 + i[7:0], 8'hff);
      acc(1'b1, 1'b0, 8'h14 + i[7:0], 8'hfe);
    end
    acc(1'b0, 1'b1, 8'h18, 8'ha5);
    acc(1'b1, 1'b0, 8'h18, 8'ha5);
    acc(1'b1, 1'b1, 8'h19, 8'h3c);
    acc(1'b0, 1'b0, 8'h19, 8'h3c);
    acc(1'b0, 1'b1, 8'h1a, 8'h77);
    acc(1'b0, 1'b0, 8'h1a, 8'h00);
  endtask
  task automatic t_xlate;
    xa(7'h7f, 1'b1, 2'h0);
    acc(1'b0, 1'b1, 8'h14, 8'h00);
    acc(1'b1, 1'b1, 8'h15, 8'h42);
    xa(7'h21, 1'b1, 2'h1);
    xa(7'h7f, 1'b1, 2'h2);
    xa(7'h10, 1'b0, 2'h0);
    xa(7'h00, 1'b0, 2'h0);
    // the model counts the last pulse on the edge after it appears
    @(posedge clk) #1;
    chk("n_fwd", n_fwd, 8'h03);
    chk("n_drop", n_drop, 8'h02);
  endtask
  // a second reset must return programmed entries and message registers to their reset values
  task automatic t_rerst;
    @(posedge clk) #1;
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    t_reset();
    xa(7'h21, 1'b0, 2'h0);
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    summarize();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    #1 rst_b = 1'b1;
    t_reset();
    t_regs();
    t_xlate();
    t_rerst();
    summarize();
  end
endmodule
`default_nettype wire
